// ==== hdl/wsc_pkg.sv ====
// constants, opcodes and host register map of the wiper serial control
// Notes on behaviour
// [RQ1] short code sits in low bits, leading bits ignored
// [RQ2] 12-bit code: first four data bits discarded
// [RQ3] shifted-through bits leave on chain data output
// [RQ4] two chained devices take one double frame
// [RQ5] host holds frame select low whole transfer
// [RQ6] frame select rising completes the command
// [RQ7] wrong serial clock count drops the frame
// [RQ8] clock counter clears while frame select high
// [RQ9] increment and decrement step all wipers together
// [RQ10] restore command reloads all wipers from memory
// [RQ11] load pin copies input register to wiper
// [RQ12] load updates selected wiper or all wipers
// [RQ13] readback returns last write-selected channel wiper
// [RQ14] host selects channel by dummy write first
// [RQ15] write protect blocks wiper changing commands
// [RQ16] write protect still allows restore from memory
// [RQ17] recall pin overwrites wipers from memory
// [RQ18] ready output shows command done; host waits
// [RQ19] without memory, reset presets wipers midscale
// [RQ20] with memory, wipers load stored value at reset
// [RQ21] store command copies wiper into memory
// [RQ22] msb first, sampled only while frame selected
package wsc_pkg;
  // ****************************************************
  // frame layout
  // ****************************************************
  localparam int FRAME_BITS = 24;
  localparam int CODE_W     = 12;
  localparam int CH         = 4;
  localparam int CH_W       = 2;
  localparam int OP_MSB     = 23;
  localparam int OP_LSB     = 20;
  localparam int CHF_MSB    = 19;
  localparam int CHF_LSB    = 16;
  localparam logic [3:0]        CH_ALL   = 4'hf;
  localparam logic [CODE_W-1:0] MIDSCALE = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_WR_INPUT = 4'h1,
    OP_WR_WIPER = 4'h2,
    OP_READ     = 4'h3,
    OP_INC_ALL  = 4'h4,
    OP_DEC_ALL  = 4'h5,
    OP_STORE_NV = 4'h6,
    OP_WR_NV    = 4'h7,
    OP_RESTORE  = 4'h8,
    OP_LOAD     = 4'h9,
    OP_SELECT   = 4'ha
  } wsc_op_e;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_NS       = 20;
  localparam int NV_WRITE_NS  = 1000;
  localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF    = 8;

  // ****************************************************
  // host register map
  // ****************************************************
  localparam logic [7:0] REG_TX0    = 8'h00;
  localparam logic [7:0] REG_TX1    = 8'h04;
  localparam logic [7:0] REG_GO     = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RX0    = 8'h10;
  localparam logic [7:0] REG_RX1    = 8'h14;
  localparam logic [7:0] REG_PINS   = 8'h18;
endpackage

// ==== hdl/wsc_link_if.sv ====
// serial link between host and wiper device
`timescale 1ns/1ps
interface wsc_link_if;
  logic sclk;
  logic frame_n;
  logic serial_in;
  logic chain_data_out;
  logic ready;
  logic load_wiper_n;
  logic write_protect_n;
  logic nonvolatile_recall_n;
  modport dev (input sclk, frame_n, serial_in, load_wiper_n, write_protect_n, nonvolatile_recall_n,
               output chain_data_out, ready);
  modport host (output sclk, frame_n, serial_in, load_wiper_n, write_protect_n, nonvolatile_recall_n,
                input chain_data_out, ready);
endinterface

// ==== hdl/wsc_device.sv ====
// wiper device end: serial port, wiper, input and memory registers
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module wsc_device
  import wsc_pkg::*;
#(
  parameter bit HAS_NV = 1'b1          // device has nonvolatile memory
) (
  input  wire logic               clk,        // system clock
  input  wire logic               srst,       // synchronous reset
  wsc_link_if.dev                 link,       // serial link
  output logic [CH*CODE_W-1:0]    wiper_code, // wiper positions, channel 0 low
  output logic                    frame_drop  // pulse: frame discarded
);
  // ****************************************************
  // state
  // ****************************************************
  typedef enum {DV_BOOT, DV_IDLE, DV_NVWR} wsc_dev_st_e;

  typedef struct packed {
    logic [1:0]                       sclk_s;
    logic [1:0]                       frame_s;
    logic [1:0]                       sin_s;
    logic [1:0]                       ld_s;
    logic [1:0]                       wp_s;
    logic [1:0]                       rc_s;
    logic                             sclk_d;
    logic                             frame_d;
    logic                             ld_d;
    logic                             rc_d;
    logic [FRAME_BITS-1:0]            sh;
    logic [$clog2(FRAME_BITS)-1:0]    bcnt;
    logic                             got;
    logic [CH-1:0][CODE_W-1:0]        inreg;
    logic [CH-1:0][CODE_W-1:0]        wiper;
    logic [CH-1:0][CODE_W-1:0]        nv;
    logic [CH_W-1:0]                  sel;
    logic                             ld_all;
    logic [15:0]                      busy;
    wsc_dev_st_e                      st;
    logic                             ready;
    logic                             drop;
  } wsc_dev_s;

  wsc_dev_s r;
  wsc_dev_s n;

  logic                   rise;
  logic                   fr_end;
  logic                   wp;
  logic                   all;
  logic [CH_W-1:0]        ch;
  logic [CODE_W-1:0]      code;
  wsc_op_e                op;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    n        = r;
    n.drop   = 1'b0;
    n.sclk_s = {r.sclk_s[0], link.sclk};
    n.frame_s = {r.frame_s[0], link.frame_n};
    n.sin_s  = {r.sin_s[0], link.serial_in};
    n.ld_s   = {r.ld_s[0], link.load_wiper_n};
    n.wp_s   = {r.wp_s[0], link.write_protect_n};
    n.rc_s   = {r.rc_s[0], link.nonvolatile_recall_n};
    n.sclk_d = r.sclk_s[1];
    n.frame_d = r.frame_s[1];
    n.ld_d   = r.ld_s[1];
    n.rc_d   = r.rc_s[1];

    rise   = r.sclk_s[1] & ~r.sclk_d;
    fr_end = r.frame_s[1] & ~r.frame_d;
    wp     = ~r.wp_s[1];
    op     = wsc_op_e'(r.sh[OP_MSB:OP_LSB]);
    all    = (r.sh[CHF_MSB:CHF_LSB] == CH_ALL);
    ch     = r.sh[CHF_LSB+CH_W-1:CHF_LSB];
    code   = r.sh[CODE_W-1:0];                     // RQ1 RQ2

    // serial shifter
    if (r.frame_s[1]) begin
      n.bcnt = '0;                                 // RQ8
      n.got  = 1'b0;
    end else if (rise) begin
      n.sh   = {r.sh[FRAME_BITS-2:0], r.sin_s[1]}; // RQ22 RQ3 RQ4
      n.bcnt = (r.bcnt == ($clog2(FRAME_BITS))'(FRAME_BITS-1)) ? '0 : r.bcnt + 1'b1;
      n.got  = 1'b1;
    end

    // ****************************************************
    // sequencer
    // ****************************************************
    unique case (r.st)
      DV_BOOT: begin
        if (HAS_NV) begin
          n.wiper = r.nv;                          // RQ20
          n.inreg = r.nv;
        end
        n.st = DV_IDLE;
      end
      DV_NVWR: begin
        n.busy = r.busy - 1'b1;
        if (r.busy == '0) begin
          n.st = DV_IDLE;
        end
      end
      DV_IDLE: begin
        // load pin falling edge
        if (!r.ld_s[1] && r.ld_d && !wp) begin     // RQ11 RQ15
          for (int i = 0; i < CH; i++) begin
            if (r.ld_all || i == int'(r.sel)) begin // RQ12
              n.wiper[i] = r.inreg[i];
            end
          end
        end
        // recall pin falling edge, allowed under protect
        if (HAS_NV && !r.rc_s[1] && r.rc_d) begin
          n.wiper = r.nv;                          // RQ17 RQ16
        end
        if (fr_end && r.got) begin                 // RQ6
          if (r.bcnt != '0) begin
            n.drop = 1'b1;                         // RQ7
          end else begin
            unique case (op)
              OP_WR_INPUT, OP_WR_WIPER, OP_LOAD: begin
                if (!wp) begin                     // RQ15
                  for (int i = 0; i < CH; i++) begin
                    if (all || i == int'(ch)) begin
                      if (op != OP_LOAD) begin
                        n.inreg[i] = code;
                      end
                      if (op == OP_WR_WIPER) begin
                        n.wiper[i] = code;
                      end
                      if (op == OP_LOAD) begin
                        n.wiper[i] = r.inreg[i];   // RQ12
                      end
                    end
                  end
                  n.sel    = ch;                   // RQ13
                  n.ld_all = all;
                end
              end
              OP_SELECT: begin
                n.sel = ch;                        // RQ14
              end
              OP_READ: begin
                n.sh = FRAME_BITS'(r.wiper[r.sel]); // RQ13
              end
              OP_INC_ALL, OP_DEC_ALL: begin
                if (!wp) begin                     // RQ15
                  for (int i = 0; i < CH; i++) begin
                    if (op == OP_INC_ALL && r.wiper[i] != CODE_MAX) begin
                      n.wiper[i] = r.wiper[i] + 1'b1; // RQ9
                    end
                    if (op == OP_DEC_ALL && r.wiper[i] != '0) begin
                      n.wiper[i] = r.wiper[i] - 1'b1; // RQ9
                    end
                  end
                end
              end
              OP_STORE_NV, OP_WR_NV: begin
                if (!wp && HAS_NV) begin           // RQ15
                  for (int i = 0; i < CH; i++) begin
                    if (all || i == int'(ch)) begin
                      n.nv[i] = (op == OP_WR_NV) ? code : r.wiper[i]; // RQ21
                    end
                  end
                  n.sel  = ch;
                  n.busy = 16'(NV_WRITE_CYC - 1);
                  n.st   = DV_NVWR;
                end
              end
              OP_RESTORE: begin
                if (HAS_NV) begin
                  n.wiper = r.nv;                  // RQ10 RQ16
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
    endcase
    if (fr_end && r.got && r.st != DV_IDLE) begin
      n.drop = 1'b1;
    end
    n.ready = (n.st == DV_IDLE);                   // RQ18
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      r         <= '0;
      r.frame_s <= 2'h3;
      r.frame_d <= 1'b1;
      r.ld_s    <= 2'h3;
      r.ld_d    <= 1'b1;
      r.wp_s    <= 2'h3;
      r.rc_s    <= 2'h3;
      r.rc_d    <= 1'b1;
      r.inreg   <= {CH{MIDSCALE}};
      r.wiper   <= {CH{MIDSCALE}};                 // RQ19
      r.nv      <= {CH{MIDSCALE}};                 // RQ20
      r.st      <= DV_BOOT;
    end else begin
      r <= n;
    end
  end

  assign link.chain_data_out = r.sh[FRAME_BITS-1]; // RQ3
  assign link.ready          = r.ready;
  assign wiper_code          = r.wiper;
  assign frame_drop          = r.drop;
endmodule

// ==== hdl/wsc_host.sv ====
// host end: register port, frame engine driving the serial link
`timescale 1ns/1ps
module wsc_host
  import wsc_pkg::*;
#(
  parameter int HB   = 48,             // longest frame in bits
  parameter int HALF = SCLK_HALF       // clk cycles per serial clock half
) (
  input  wire logic         clk,       // system clock
  input  wire logic         srst,      // synchronous reset
  wsc_link_if.host          link,      // serial link
  input  wire logic [7:0]   addr,      // register byte address
  input  wire logic [31:0]  wdata,     // write data
  input  wire logic         wr,        // write strobe
  input  wire logic         rd,        // read strobe
  output logic [31:0]       rdata      // read data, cycle after rd
);
  localparam int NB_W = $clog2(HB + 1);

  // ****************************************************
  // state
  // ****************************************************
  typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} wsc_host_st_e;

  typedef struct packed {
    wsc_host_st_e     st;
    logic             sclk;
    logic             frame_n;
    logic             sin;
    logic [2:0]       pins;
    logic [15:0]      div;
    logic [NB_W-1:0]  nbits;
    logic [NB_W-1:0]  cnt;
    logic             pend;
    logic [HB-1:0]    tx;
    logic [HB-1:0]    sh;
    logic [HB-1:0]    rx;
    logic [1:0]       co_s;
    logic [1:0]       rdy_s;
    logic [31:0]      rdata;
  } wsc_host_s;

  wsc_host_s r;
  wsc_host_s n;
  logic      tick;

  always_comb begin
    n       = r;
    n.rdata = '0;
    n.co_s  = {r.co_s[0], link.chain_data_out};
    n.rdy_s = {r.rdy_s[0], link.ready};
    tick    = (r.div == '0);
    n.div   = tick ? 16'(HALF - 1) : r.div - 1'b1;

    // ****************************************************
    // register port
    // ****************************************************
    if (wr) begin
      unique case (addr)
        REG_TX0:  n.tx[23:0]  = wdata[23:0];
        REG_TX1:  n.tx[HB-1:24] = wdata[HB-25:0];
        REG_GO:   if (r.st == HS_IDLE && !r.pend && wdata[NB_W-1:0] != '0 &&
                      wdata[NB_W-1:0] <= NB_W'(HB)) begin
                    n.pend  = 1'b1;
                    n.nbits = wdata[NB_W-1:0];
                  end
        REG_PINS: n.pins = wdata[2:0];
        default:  ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        REG_TX0:    n.rdata = 32'(r.tx[23:0]);
        REG_TX1:    n.rdata = 32'(r.tx[HB-1:24]);
        REG_GO:     n.rdata = 32'(r.nbits);
        REG_STATUS: n.rdata = {30'h0000_0000, r.rdy_s[1], r.pend};
        REG_RX0:    n.rdata = 32'(r.rx[23:0]);
        REG_RX1:    n.rdata = 32'(r.rx[HB-1:24]);
        REG_PINS:   n.rdata = 32'(r.pins);
        default:    n.rdata = '0;
      endcase
    end

    // ****************************************************
    // frame engine
    // ****************************************************
    unique case (r.st)
      HS_IDLE: begin
        if (r.pend && r.rdy_s[1]) begin            // RQ18
          n.sh      = r.tx << (HB - int'(r.nbits));
          n.sin     = r.tx[r.nbits - 1'b1];        // RQ22
          n.frame_n = 1'b0;                        // RQ5
          n.cnt     = '0;
          n.div     = 16'(HALF - 1);
          n.st      = HS_LOW;
        end
      end
      HS_LOW: if (tick) begin
        n.sclk = 1'b1;
        n.rx   = {r.rx[HB-2:0], r.co_s[1]};
        n.cnt  = r.cnt + 1'b1;
        n.st   = HS_HIGH;
      end
      HS_HIGH: if (tick) begin
        n.sclk = 1'b0;
        if (r.cnt == r.nbits) begin
          n.st = HS_TAIL;
        end else begin
          n.sh  = r.sh << 1;                       // RQ4
          n.sin = r.sh[HB-2];
          n.st  = HS_LOW;
        end
      end
      HS_TAIL: if (tick) begin
        n.frame_n = 1'b1;                          // RQ6
        n.st      = HS_GAP;
      end
      HS_GAP: if (tick) begin
        n.pend = 1'b0;
        n.st   = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r         <= '0;
      r.frame_n <= 1'b1;
      r.pins    <= 3'h7;
      r.st      <= HS_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.sclk                 = r.sclk;
  assign link.frame_n              = r.frame_n;
  assign link.serial_in            = r.sin;
  assign link.load_wiper_n         = r.pins[0];
  assign link.write_protect_n      = r.pins[1];
  assign link.nonvolatile_recall_n = r.pins[2];
  assign rdata                     = r.rdata;
endmodule

// ==== tb/wsc_checker.sv ====
// concurrent checks on the serial link between host and wiper device
`timescale 1ns/1ps
module wsc_checker #(
  parameter int HB = 48               // longest frame in bits
) (
  input wire logic clk,               // system clock
  input wire logic srst,              // synchronous reset
  input wire logic sclk,              // serial clock
  input wire logic frame_n,           // frame select
  input wire logic serial_in,         // data host to device
  input wire logic ready              // device idle
);
  // ****************************************************
  // helper: serial clock rises in the current frame
  // ****************************************************
  int rises;

  always_ff @(posedge clk) begin
    if (srst || frame_n) begin
      rises <= 0;
    end else if ($rose(sclk)) begin
      rises <= rises + 1;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_high;
    sclk [*7] ##1 !sclk;
  endsequence
  sequence s_busy;
    (!ready) [*8] ##[30:60] ready;
  endsequence
  sequence s_start;
    $fell(frame_n);
  endsequence

  sclk_idle_a:   assert property (frame_n |-> !sclk) else $error("serial clock runs outside a frame");
  data_stable_a: assert property (sclk && $past(sclk) |-> $stable(serial_in))
                   else $error("serial data moved while clock high");
  high_phase_a:  assert property ($rose(sclk) |=> s_high) else $error("serial clock high phase wrong");
  low_phase_a:   assert property ($fell(sclk) |=> (!sclk) [*7]) else $error("serial clock low phase short");
  start_ready_a: assert property (s_start |-> ready) else $error("frame started while device busy");
  first_edge_a:  assert property (s_start |-> ##[7:9] $rose(sclk)) else $error("first clock edge late");
  busy_time_a:   assert property ($fell(ready) |=> s_busy) else $error("memory write busy time wrong");
  frame_len_a:   assert property ($rose(frame_n) |-> rises >= 1 && rises <= HB)
                   else $error("frame bit count out of range");
endmodule

// ==== tb/wiper_serial_control_test.sv ====
// self-checking bench: host and wiper device joined, compared with a model
`timescale 1ns/1ps
module wiper_serial_control_test;
  import wsc_pkg::*;
  logic        clk;
  logic        srst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [47:0] wiper_code;
  logic        frame_drop;
  integer      seed;
  int          n_errors;
  int          check_count;
  int          n_drop = 0;
  int          sel;
  int          wp;
  int          ldall = 0;
  int          i;
  int          wm[4];
  int          im[4];
  int          nm[4];
  logic [11:0] c2;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  wsc_link_if wsc_link_if_i ();
  wsc_host wsc_host_i (.clk(clk), .srst(srst), .link(wsc_link_if_i), .addr(addr), .wdata(wdata),
                       .wr(wr), .rd(rd), .rdata(rdata));
  wsc_device wsc_device_i (.clk(clk), .srst(srst), .link(wsc_link_if_i), .wiper_code(wiper_code),
                           .frame_drop(frame_drop));
  wsc_checker wsc_checker_i (.clk(clk), .srst(srst), .sclk(wsc_link_if_i.sclk), .frame_n(wsc_link_if_i.frame_n),
                             .serial_in(wsc_link_if_i.serial_in), .ready(wsc_link_if_i.ready));

  always @(posedge clk) if (frame_drop === 1'b1) n_drop <= n_drop + 1;

  // ****************************************************
  // tasks
  // ****************************************************
  task summarize;
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task chkw;
    for (int k = 0; k < 4; k++) chk("wiper", wm[k], {20'h0, wiper_code[12*k+:12]});
  endtask

  task send(input logic [31:0] hi, input logic [31:0] lo, input int n);
    int k;
    wreg(REG_TX1, hi);
    wreg(REG_TX0, lo);
    wreg(REG_GO, n);
    for (k = 0; k < 5000; k++) begin
      rreg(REG_STATUS);
      if (v[0] === 1'b0) break;
    end
    if (k == 5000) begin
      n_errors++;
      summarize();
    end
    repeat (8) @(posedge clk);
  endtask

  task pins(input logic [2:0] p);
    wreg(REG_PINS, {29'h0, p});
    repeat (10) @(posedge clk);
  endtask

  // load pin pulse, mirrored in the model: selected channel or all
  task ldpin;
    pins(3'b110);
    for (int k = 0; k < 4; k++) if (ldall != 0 || k == sel) wm[k] = im[k];
    chkw();
    pins(3'b111);
  endtask

  // one 24-bit command with random ignored nibble, mirrored in the model
  task op(input logic [3:0] o, input logic [3:0] ch, input logic [11:0] code);
    int c;
    c = ch[1:0];
    send(32'h0, {8'h00, o, ch, 4'($random(seed)), code}, 24);
    if (!(wp != 0 && o inside {1, 2, 4, 5, 6, 7, 9})) begin
      if (o inside {1, 2, 6, 7, 9, 10}) sel = c;
      if (o inside {1, 2, 9}) ldall = (ch == 4'hf);
      case (o)
        OP_INC_ALL:  for (int k = 0; k < 4; k++) wm[k] = (wm[k] == 4095) ? 4095 : wm[k] + 1;
        OP_DEC_ALL:  for (int k = 0; k < 4; k++) wm[k] = (wm[k] == 0) ? 0 : wm[k] - 1;
        OP_RESTORE:  wm = nm;
        default: begin
          // channel field 0xf addresses every channel
          for (int k = 0; k < 4; k++) begin
            if (ch == 4'hf || k == c) begin
              if (o inside {1, 2}) im[k] = code;
              if (o == OP_WR_WIPER) wm[k] = code;
              if (o == OP_STORE_NV) nm[k] = wm[k];
              if (o == OP_WR_NV) nm[k] = code;
              if (o == OP_LOAD) wm[k] = im[k];
            end
          end
        end
      endcase
    end
    chkw();
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    seed = 32'hc4a4; n_errors = 0; check_count = 0; sel = 0; wp = 0;
    for (i = 0; i < 4; i++) begin
      wm[i] = 2048; im[i] = 2048; nm[i] = 2048;
    end
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chkw();
    rreg(8'h40);
    chk("unmapped", 32'h0, v);
    rreg(REG_STATUS);
    chk("ready", 32'h1, {31'h0, v[1]});
    for (i = 0; i < 4; i++) op(OP_WR_WIPER, 4'(i), 12'($random(seed)));
    op(OP_WR_WIPER, 0, 12'hfff);
    op(OP_WR_WIPER, 1, 12'h000);
    op(OP_INC_ALL, 0, 0);
    op(OP_DEC_ALL, 0, 0);
    op(OP_DEC_ALL, 0, 0);
    op(OP_WR_WIPER, 2, 12'($random(seed)));
    op(OP_READ, 0, 0);
    op(OP_NOP, 0, 0);
    rreg(REG_RX0);
    chk("readback", wm[2], {20'h0, v[11:0]});
    op(4'hb, 0, 0);
    op(OP_SELECT, 1, 0);
    op(OP_READ, 0, 0);
    op(OP_NOP, 0, 0);
    rreg(REG_RX0);
    chk("readback", wm[1], {20'h0, v[11:0]});
    op(OP_WR_INPUT, 3, 12'($random(seed)));
    op(OP_LOAD, 3, 0);
    op(OP_WR_INPUT, 0, 12'($random(seed)));
    op(OP_WR_INPUT, 1, 12'($random(seed)));
    op(OP_LOAD, 4'hf, 0);
    op(OP_WR_INPUT, 2, 12'($random(seed)));
    ldpin();
    op(OP_WR_INPUT, 4'hf, 12'($random(seed)));
    ldpin();
    op(OP_STORE_NV, 2, 0);
    op(OP_WR_NV, 0, 12'($random(seed)));
    op(OP_WR_WIPER, 2, 12'($random(seed)));
    op(OP_RESTORE, 0, 0);
    op(OP_WR_WIPER, 3, 12'($random(seed)));
    pins(3'b011);
    wm = nm;
    chkw();
    pins(3'b111);
    send(32'h0, {8'h00, 4'h2, 4'h0, 4'h0, 12'($random(seed))}, 20);
    chkw();
    chk("drops", 32'h1, n_drop);
    op(OP_WR_WIPER, 0, 12'($random(seed)));
    c2 = 12'($random(seed));
    send({8'h00, 4'h2, 4'h1, 4'h0, 12'h5a5}, {8'h00, 4'h2, 4'h3, 4'h0, c2}, 48);
    wm[3] = c2;
    im[3] = c2;
    sel = 3;
    ldall = 0;
    chkw();
    rreg(REG_RX0);
    chk("chain", {8'h00, 4'h2, 4'h1, 4'h0, 12'h5a5}, {8'h00, v[23:0]});
    op(OP_WR_INPUT, 0, 12'($random(seed)));
    wp = 1;
    pins(3'b101);
    op(OP_WR_WIPER, 1, 12'($random(seed)));
    op(OP_INC_ALL, 0, 0);
    op(OP_WR_NV, 1, 12'($random(seed)));
    pins(3'b100);
    chkw();
    pins(3'b101);
    op(OP_RESTORE, 0, 0);
    summarize();
  end
endmodule
